// ==== core/dcr_pkg.sv ====
// shared constants for the dual converter conversion and result read port
package dcr_pkg;
	// ------------------------------------------------------------
	// widths and frame layout
	// ------------------------------------------------------------
	localparam int RESULT_W = 12;
	localparam int RESULT_MSB = 11;
	localparam int LANES = 4;
	localparam int FRAME_W = RESULT_W * LANES;
	localparam int LANE_A_ONE = 0;
	localparam int LANE_A_TWO = 1;
	localparam int LANE_B_ONE = 2;
	localparam int LANE_B_TWO = 3;
	localparam int FIFO_DEPTH = 32;
	// flipping the msb of a straight binary code gives two's complement
	localparam logic [RESULT_W-1:0] BIPOLAR_FLIP = 12'h800;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int CONV_TIME_NS = 3600;
	// longest time, rounded down, never below one cycle
	localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
	localparam int CNT_W = 8;

	typedef enum logic [1:0] {
		DCR_IDLE,
		DCR_WAIT_FRAME,
		DCR_CONVERT
	} dcr_state_t;
endpackage : dcr_pkg

// ==== core/dcr_stream_if.sv ====
// valid/ready stream carrier between the port logic and its sample fifo
`timescale 1ns/100ps
`default_nettype none
interface dcr_stream_if #(
	parameter int WIDTH = 48
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dcr_stream_if
`default_nettype wire

// ==== core/dcr_fifo.sv ====
// parameterised fifo holding sampled input frames ahead of the track/hold
`timescale 1ns/100ps
`default_nettype none
module dcr_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	dcr_stream_if.snk wr,
	dcr_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("dcr_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic ready_reg;
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	assign push = wr.valid && ready_reg;
	assign pop = rd.valid && rd.ready;
	assign wr.ready = ready_reg;
	assign rd.valid = (count_reg != '0);
	assign rd.data = mem[rptr_reg];

	// next occupancy, also used to precompute a registered ready
	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// storage has no reset; only the pointers define what is valid
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr_reg] <= wr.data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH)); // registered so the port sees a flop
		end
	end

	chk_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
		(count_reg == (AW+1)'(DEPTH)) |-> !wr.ready)
		else $error("fifo ready while full");
	cov_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i)
		count_reg == (AW+1)'(DEPTH));
endmodule : dcr_fifo
`default_nettype wire

// ==== core/dcr_top.sv ====
// conversion control and result read port of a dual simultaneous-sampling converter
//
// Contract
// - a falling conversion start puts both track/holds into hold and starts both conversions.
// - busy rises on the falling conversion start and stays high until both results are done.
// - the result bus is driven from one clock after read strobe and chip select are both low until one clock after either rises.
// - the result bus is twelve three-state lines with bit 11 as the msb.
// - with pair select low the first read returns pair A input one, the next pair A input two.
// - with pair select high successive reads return pair B input one, then input two.
// - bipolar variants present results in two's complement.
// - the unipolar variant presents results in straight binary.
// - chip select is active low and reads are answered only while it is low.
`timescale 1ns/100ps
`default_nettype none
module dcr_top
	import dcr_pkg::*;
#(
	parameter bit BIPOLAR = 1'b1,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic conversion_start_n_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic pair_select_i,
	input wire logic sample_valid_i,
	input wire logic [FRAME_W-1:0] sample_data_i,
	output logic sample_ready_o,
	output logic busy_o,
	output logic [RESULT_W-1:0] result_bus_o,
	output logic result_bus_oe_o
);
	generate
		if (CONV_CYCLES >= (1 << CNT_W)) begin : g_bad_count
			$error("conversion count does not fit its counter");
		end
	endgenerate

	// ------------------------------------------------------------
	// sample frame fifo
	// ------------------------------------------------------------
	dcr_stream_if #(.WIDTH(FRAME_W)) in_if ();
	dcr_stream_if #(.WIDTH(FRAME_W)) hold_if ();

	assign in_if.valid = sample_valid_i;
	assign in_if.data = sample_data_i;

	dcr_fifo #(.WIDTH(FRAME_W), .DEPTH(DEPTH)) u_fifo (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.wr(in_if),
		.rd(hold_if)
	);

	dcr_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic conv_prev_reg;
	logic rd_prev_reg;
	logic ptr_reg;
	logic busy_reg;
	logic [FRAME_W-1:0] held_reg;
	logic [RESULT_W-1:0] res_reg [LANES];
	logic [RESULT_W-1:0] coded [LANES];
	logic [RESULT_W-1:0] data_reg;
	logic oe_reg;
	logic conv_fall;
	logic take_frame;
	logic conv_done;
	logic rd_act;
	logic rd_start;
	logic rd_end;
	logic [1:0] lane_sel;

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	assign conv_fall = conv_prev_reg && !conversion_start_n_i;
	assign hold_if.ready = (state_reg == DCR_WAIT_FRAME);
	assign take_frame = hold_if.valid && hold_if.ready;
	assign conv_done = (state_reg == DCR_CONVERT) && (cnt_reg == '0);
	assign rd_act = !cs_n_i && !rd_n_i;
	assign rd_start = rd_act && !rd_prev_reg;
	assign rd_end = !rd_act && rd_prev_reg;
	assign lane_sel = {pair_select_i, ptr_reg};

	// edge history of the start and read strobes
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			conv_prev_reg <= 1'b1;
			rd_prev_reg <= 1'b0;
		end else begin
			conv_prev_reg <= conversion_start_n_i;
			rd_prev_reg <= rd_act;
		end
	end

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	// a start edge while busy is ignored; the frame at the fifo head is the held input
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg <= DCR_IDLE;
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				DCR_IDLE: begin
					if (conv_fall) begin
						state_reg <= DCR_WAIT_FRAME;
						busy_reg <= 1'b1;
					end
				end
				DCR_WAIT_FRAME: begin
					if (take_frame) begin
						state_reg <= DCR_CONVERT;
						cnt_reg <= CNT_W'(CONV_CYCLES - 1);
					end
				end
				DCR_CONVERT: begin
					if (conv_done) begin
						state_reg <= DCR_IDLE;
						busy_reg <= 1'b0;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
			endcase
		end
	end

	// track/hold: both pairs are frozen together from one frame
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			held_reg <= '0;
		end else if (take_frame) begin
			held_reg <= hold_if.data;
		end
	end

	// output coding per lane, fixed by the input range variant
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			assign coded[gi] = BIPOLAR ? (held_reg[gi*RESULT_W +: RESULT_W] ^ BIPOLAR_FLIP)
				: held_reg[gi*RESULT_W +: RESULT_W];
			always_ff @(posedge mclk_i) begin
				if (rst_i) begin
					res_reg[gi] <= RESULT_RESET;
				end else if (conv_done) begin
					res_reg[gi] <= coded[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// pointer restarts at every conversion; it steps when a read strobe ends
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ptr_reg <= 1'b0;
		end else if (conv_fall && state_reg == DCR_IDLE) begin
			ptr_reg <= 1'b0;
		end else if (rd_end) begin
			ptr_reg <= !ptr_reg;
		end
	end

	// word latched at strobe start so it stays steady for the whole read
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			data_reg <= RESULT_RESET;
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= rd_act;
			if (rd_start) begin
				data_reg <= res_reg[lane_sel];
			end
		end
	end

	// the enable lags the strobes by one clock; the pad turns it into high impedance
	assign result_bus_o = data_reg;
	assign result_bus_oe_o = oe_reg;
	assign busy_o = busy_reg;

	// the fifo's ready is already a flop, so it leaves the block with no gate after it
	assign sample_ready_o = in_if.ready;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	chk_busy_on_start: assert property ((conv_fall && state_reg == DCR_IDLE) |=> busy_o)
		else $error("busy did not rise on conversion start");
	chk_busy_until_done: assert property ((state_reg != DCR_IDLE) |-> busy_o)
		else $error("busy dropped before conversion end");
	chk_busy_release: assert property (conv_done |=> !busy_o ##0 (res_reg[LANE_A_ONE] == $past(coded[LANE_A_ONE])))
		else $error("busy or result wrong after conversion end");
	chk_hold_frame: assert property (take_frame |=> held_reg == $past(hold_if.data))
		else $error("held frame differs from fifo head");
	chk_oe_gated: assert property (result_bus_oe_o |-> $past(!cs_n_i && !rd_n_i))
		else $error("result bus driven without read and select");
	chk_oe_on_read: assert property ((!cs_n_i && !rd_n_i) |=> result_bus_oe_o)
		else $error("result bus not driven during read");
	chk_ptr_restart: assert property ((conv_fall && state_reg == DCR_IDLE) |=> !ptr_reg)
		else $error("read pointer not restarted");
	chk_pair_a_order: assert property ((rd_start && !pair_select_i) |=> result_bus_o ==
		$past(ptr_reg ? res_reg[LANE_A_TWO] : res_reg[LANE_A_ONE]))
		else $error("wrong pair A word");
	chk_pair_b_order: assert property ((rd_start && pair_select_i) |=> result_bus_o ==
		$past(ptr_reg ? res_reg[LANE_B_TWO] : res_reg[LANE_B_ONE]))
		else $error("wrong pair B word");
	chk_lane_coding: assert property (conv_done |=> res_reg[LANE_B_TWO][RESULT_MSB] ==
		($past(held_reg[FRAME_W-1]) ^ BIPOLAR))
		else $error("msb coding wrong for range variant");

	cov_conversion: cover property (conv_fall ##[1:300] conv_done);
	cov_read_pair_a: cover property ((rd_start && !pair_select_i && !ptr_reg) ##[2:50]
		(rd_start && !pair_select_i && ptr_reg));
	cov_read_pair_b: cover property ((rd_start && pair_select_i && !ptr_reg) ##[2:50]
		(rd_start && pair_select_i && ptr_reg));
	cov_start_ignored: cover property (busy_o && conv_fall);
endmodule : dcr_top
`default_nettype wire

// ==== test/dcr_host_model.sv ====
// host controller model driving conversion and read strobes
`timescale 1ns/100ps
`default_nettype none
module dcr_host_model
	import dcr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic busy_i,
	input wire logic [RESULT_W-1:0] bus_i,
	input wire logic bus_oe_i,
	output logic conv_n_o,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic psel_o
);
	// idle host: all strobes inactive
	initial begin
		conv_n_o = 1'b1;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		psel_o = 1'b0;
	end

	// two-cycle start pulse, then count busy cycles under a bound
	task automatic convert(output int n);
		@(negedge mclk_i);
		conv_n_o = 1'b0;
		repeat (2) @(negedge mclk_i);
		conv_n_o = 1'b1;
		n = 0;
		while (busy_i && n < 1000) begin
			n++;
			@(negedge mclk_i);
		end
		// track/hold settles before anyone starts again
		repeat (12) @(negedge mclk_i);
	endtask : convert

	// one strobe; a released bus reads back inverted, never a stale match
	task automatic read_word(input logic sel, input logic cs, output logic [RESULT_W-1:0] w,
		output logic oe, output logic oe_off);
		@(negedge mclk_i);
		psel_o = sel;
		cs_n_o = cs;
		rd_n_o = 1'b0;
		repeat (2) @(negedge mclk_i);
		w = bus_oe_i ? bus_i : ~bus_i;
		oe = bus_oe_i;
		rd_n_o = 1'b1;
		cs_n_o = 1'b1;
		repeat (2) @(negedge mclk_i);
		oe_off = bus_oe_i;
	endtask : read_word
endmodule : dcr_host_model
`default_nettype wire

// ==== test/test_dual_adc_convert_read_port.sv ====
// self-checking bench for the dual converter read port
`timescale 1ns/100ps
`default_nettype none
module test_dual_adc_convert_read_port;
	import dcr_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic valid = 1'b0;
	logic [FRAME_W-1:0] data = '0;
	logic conv_n, cs_n, rd_n, psel, ready, busy, oe, oe_u, sel, got_oe, got_off;
	logic [RESULT_W-1:0] bus, bus_u, w, w_u;
	logic [FRAME_W-1:0] q[$];
	logic [FRAME_W-1:0] f;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 32'hb802_7314;
	int cyc = 0;
	int n;

	always #12.5 mclk_i = ~mclk_i;

	dcr_top #(.BIPOLAR(1'b1)) u_dcr_top (.mclk_i(mclk_i), .rst_i(rst_i),
		.conversion_start_n_i(conv_n), .cs_n_i(cs_n), .rd_n_i(rd_n), .pair_select_i(psel),
		.sample_valid_i(valid), .sample_data_i(data), .sample_ready_o(ready),
		.busy_o(busy), .result_bus_o(bus), .result_bus_oe_o(oe));
	// unipolar twin sees the same host and frames
	dcr_top #(.BIPOLAR(1'b0)) u_dcr_top_uni (.mclk_i(mclk_i), .rst_i(rst_i),
		.conversion_start_n_i(conv_n), .cs_n_i(cs_n), .rd_n_i(rd_n), .pair_select_i(psel),
		.sample_valid_i(valid), .sample_data_i(data), .sample_ready_o(),
		.busy_o(), .result_bus_o(bus_u), .result_bus_oe_o(oe_u));
	dcr_host_model u_dcr_host_model (.mclk_i(mclk_i), .busy_i(busy), .bus_i(bus),
		.bus_oe_i(oe), .conv_n_o(conv_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .psel_o(psel));

	// hang guard: about three times the expected run
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic cmp_w(input logic [RESULT_W-1:0] g, input logic [RESULT_W-1:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_w

	task automatic cmp_c(input logic [10:0] g, input logic [10:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_c

	// lane word of the held frame; bipolar coding flips the msb
	function automatic logic [RESULT_W-1:0] exp_word(input logic [FRAME_W-1:0] fr,
		input logic s, input int i, input logic bip);
		exp_word = fr[(2 * int'(s) + i) * RESULT_W +: RESULT_W] ^ {bip, 11'h000};
	endfunction : exp_word

	task automatic rd_chk(input logic s, input int i);
		fork
			u_dcr_host_model.read_word(s, 1'b0, w, got_oe, got_off);
			// the twin's word is taken while its enable stands, as the host takes its own
			begin
				repeat (3) @(negedge mclk_i);
				w_u = oe_u ? bus_u : ~bus_u;
			end
		join
		cmp_w(w, exp_word(f, s, i, 1'b1));
		cmp_w(w_u, exp_word(f, s, i, 1'b0));
		cmp_c(got_oe, 1'b1);
		cmp_c(got_off, 1'b0);
	endtask : rd_chk

	initial begin
		repeat (16) @(negedge mclk_i);
		rst_i = 1'b0;
		cmp_c(busy, 1'b0);
		cmp_c(oe, 1'b0);
		repeat (3) @(negedge mclk_i);
		// fill the sample fifo until it refuses; first frame holds code extremes
		valid = 1'b1;
		while (ready && q.size() < 40) begin
			f = FRAME_W'({$random(seed), $random(seed)});
			if (q.size() == 0) f = {12'hfff, 12'h800, 12'h7ff, 12'h000};
			data = f;
			q.push_back(f);
			@(negedge mclk_i);
		end
		valid = 1'b0;
		cmp_c(11'(q.size()), 11'(FIFO_DEPTH));
		// drain it; the last start finds the fifo empty and waits for a late frame
		for (int k = 0; k < 33; k++) begin
			sel = 1'($random(seed));
			if (k == 32) fork
				begin
					repeat (40) @(negedge mclk_i);
					data = FRAME_W'({$random(seed), $random(seed)});
					q.push_back(data);
					valid = 1'b1;
					@(negedge mclk_i);
					valid = 1'b0;
				end
			join_none
			u_dcr_host_model.convert(n);
			if (k < 32) cmp_c(11'(n), 11'(CONV_CYCLES));
			else cmp_c(11'(n > CONV_CYCLES), 11'(1));
			f = q.pop_front();
			rd_chk(sel, 0);
			u_dcr_host_model.read_word(sel, 1'b1, w, got_oe, got_off);
			cmp_c(got_oe, 1'b0);
			rd_chk(sel, 1);
			// odd rounds wrap to input one, so the next start must rewind
			if (k[0]) rd_chk(sel, 0);
		end
		tally_and_finish();
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
endmodule : test_dual_adc_convert_read_port
`default_nettype wire
